// >>> inc/pdrc_consts.vh
// Purpose: Constants of the power-down and reset control block
// Assumes: 125 MHz core clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
//
// Summary of operation
// - With sleep option set, either sleep request high enters low power.
// - Asleep, all cell state and enabled outputs hold entry values.
// - Asleep, all pin transitions are ignored until requests go low.
// - Sleep option set: sleep pins are not logic pins; cells stay usable.
// - Each cell has a reduced-power bit, default off, adding delay.
// - Each output has an edge-rate bit, default slow.
// - After power-up reset, registers initialise; outputs follow polarity.
// - Fuse set refuses pattern readback; 16-bit user ID stays readable.
// - Configuration loads over a four-pin serial test port.
`ifndef PDRC_CONSTS_VH
`define PDRC_CONSTS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PDRC_CELLS 8
`define PDRC_AW 8
`define PDRC_PAT_W 32
`define PDRC_UID_W 16

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PDRC_OFS_CTRL 8'h00
`define PDRC_OFS_RPWR 8'h04
`define PDRC_OFS_SLEW 8'h08
`define PDRC_OFS_POL 8'h0c
`define PDRC_OFS_OE 8'h10
`define PDRC_OFS_STATUS 8'h14
`define PDRC_OFS_UID 8'h18
`define PDRC_OFS_PAT 8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDRC_CTRL_SLEEP_EN 0
`define PDRC_CTRL_FUSE 1
`define PDRC_ST_ASLEEP 0
`define PDRC_ST_SETTLING 1
`define PDRC_ST_FUSE 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDRC_RST_CTRL 2'h0
`define PDRC_RST_RPWR 8'h00
`define PDRC_RST_SLEW 8'h00
`define PDRC_RST_POL 8'h00
`define PDRC_RST_OE 8'h00
`define PDRC_RST_UID 16'h0000
`define PDRC_RST_PAT 32'h00000000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PDRC_CLK_PERIOD_NS 8
`define PDRC_SETTLE_NS 100
`define PDRC_SETTLE_CYC ((`PDRC_SETTLE_NS + `PDRC_CLK_PERIOD_NS - 1) / `PDRC_CLK_PERIOD_NS)
`define PDRC_SETTLE_CW 4

`endif

// >>> rtl/pdrc_cell.v
// Purpose: One logic cell with freeze and reduced-power option
// Assumes: Single core clock, asynchronous active-low reset
// Notes:   Reduced power adds one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module pdrc_cell (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_init,
  input wire i_hold,
  input wire i_rpwr,
  input wire i_d,
  output wire o_q
);

  reg stage_q;
  reg q_q;

  // ----------------------------------------------------------------
  // Cell state
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stage_q <= 1'b0;
      q_q <= 1'b0;
    end else if (i_init) begin
      stage_q <= 1'b0;
      q_q <= 1'b0;
    end else if (!i_hold) begin
      stage_q <= i_d;
      q_q <= i_rpwr ? stage_q : i_d;
    end
  end

  assign o_q = q_q;

endmodule
`default_nettype wire

// >>> rtl/pdrc_top.v
// Purpose: Power-down, power-up reset and configuration control
// Assumes: All inputs synchronous to i_core_clk; APB slave at 125 MHz
// Notes:   One wait-free access phase; unmapped addresses give pslverr
`timescale 1ns/1ps
`default_nettype none
`include "pdrc_consts.vh"
module pdrc_top (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_sleep_request_a,
  input wire i_sleep_request_b,
  input wire [7:0] i_pin_in,
  output reg [7:0] o_pin_out,
  output reg [7:0] o_pin_oe_n,
  output reg [7:0] o_fast_slew,
  output reg o_asleep,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  output reg o_tdo
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `PDRC_OFS_CTRL) || (a == `PDRC_OFS_RPWR) ||
               (a == `PDRC_OFS_SLEW) || (a == `PDRC_OFS_POL) ||
               (a == `PDRC_OFS_OE) || (a == `PDRC_OFS_STATUS) ||
               (a == `PDRC_OFS_UID) || (a == `PDRC_OFS_PAT);
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [1:0] ctrl_q;
  reg [7:0] rpwr_q;
  reg [7:0] slew_q;
  reg [7:0] pol_q;
  reg [7:0] oe_q;
  reg [15:0] uid_q;
  reg [31:0] pat_q;
  reg [31:0] shift_q;
  reg tck_q;
  reg asleep_q;
  reg settling_q;
  reg [`PDRC_SETTLE_CW-1:0] settle_cnt_q;
  reg [31:0] rdata_d;
  reg err_d;
  wire [7:0] cell_q;
  wire [7:0] cell_d;
  wire sleep_en;
  wire fuse;
  wire wr_en;
  wire setup;
  wire tck_rise;
  wire sleep_req;

  assign sleep_en = ctrl_q[`PDRC_CTRL_SLEEP_EN];
  assign fuse = ctrl_q[`PDRC_CTRL_FUSE];
  assign setup = i_psel && !i_penable;
  // Write lands in the single access cycle
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
  assign tck_rise = i_tck && !tck_q && !asleep_q;
  assign sleep_req = sleep_en && (i_sleep_request_a || i_sleep_request_b);

  // ----------------------------------------------------------------
  // Power-up settle
  // ----------------------------------------------------------------
  // registers initialised
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      settling_q <= 1'b1;
      settle_cnt_q <= {`PDRC_SETTLE_CW{1'b0}};
    end else if (settling_q) begin
      // Counts only while settling
      if (settle_cnt_q == `PDRC_SETTLE_CYC - 1) begin
        settling_q <= 1'b0;
      end
      settle_cnt_q <= settle_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sleep state
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      asleep_q <= 1'b0;
      o_asleep <= 1'b0;
    end else begin
      asleep_q <= sleep_req;
      o_asleep <= sleep_req;
    end
  end

  // ----------------------------------------------------------------
  // Logic cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PDRC_CELLS; gi = gi + 1) begin : g_cell
      wire pin;
      wire fold;
      if (gi == 0) begin : g_a
        assign pin = sleep_en ? 1'b0 : i_sleep_request_a;
      end else if (gi == 1) begin : g_b
        assign pin = sleep_en ? 1'b0 : i_sleep_request_b;
      end else begin : g_io
        assign pin = i_pin_in[gi];
      end
      assign fold = cell_q[(gi + 7) % 8];
      assign cell_d[gi] = pin ^ pat_q[gi] ^ (pat_q[gi + 8] & fold);
      pdrc_cell u_cell (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_init(settling_q),
        .i_hold(asleep_q),
        .i_rpwr(rpwr_q[gi]),
        .i_d(cell_d[gi]),
        .o_q(cell_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_out <= `PDRC_RST_POL;
      o_pin_oe_n <= 8'hff;
      o_fast_slew <= `PDRC_RST_SLEW;
    end else if (!asleep_q) begin
      o_pin_out <= cell_q ^ pol_q;
      o_pin_oe_n <= ~(oe_q & (sleep_en ? 8'hfc : 8'hff));
      o_fast_slew <= slew_q;
    end
  end

  // ----------------------------------------------------------------
  // Serial configuration port
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tck_q <= 1'b0;
      shift_q <= 32'h00000000;
      o_tdo <= 1'b0;
    end else begin
      // Edge detect tracks the clock even while asleep
      tck_q <= i_tck;
      if (tck_rise && !i_tms) begin
        shift_q <= {i_tdi, shift_q[31:1]};
        o_tdo <= fuse ? 1'b0 : shift_q[0];
      end else if (tck_rise && i_tms && !fuse) begin
        shift_q <= pat_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= `PDRC_RST_CTRL;
      rpwr_q <= `PDRC_RST_RPWR;
      slew_q <= `PDRC_RST_SLEW;
      pol_q <= `PDRC_RST_POL;
      oe_q <= `PDRC_RST_OE;
      uid_q <= `PDRC_RST_UID;
      pat_q <= `PDRC_RST_PAT;
    end else begin
      if (tck_rise && i_tms) begin
        pat_q <= shift_q;
      end else if (wr_en && hit(i_paddr, `PDRC_OFS_PAT)) begin
        pat_q <= i_pwdata;
      end
      if (wr_en && hit(i_paddr, `PDRC_OFS_CTRL)) begin
        ctrl_q[`PDRC_CTRL_SLEEP_EN] <= i_pwdata[`PDRC_CTRL_SLEEP_EN];
        // Fuse only sets
        ctrl_q[`PDRC_CTRL_FUSE] <= fuse | i_pwdata[`PDRC_CTRL_FUSE];
      end
      if (wr_en && hit(i_paddr, `PDRC_OFS_RPWR)) begin
        rpwr_q <= i_pwdata[7:0];
      end
      if (wr_en && hit(i_paddr, `PDRC_OFS_SLEW)) begin
        slew_q <= i_pwdata[7:0];
      end
      if (wr_en && hit(i_paddr, `PDRC_OFS_POL)) begin
        pol_q <= i_pwdata[7:0];
      end
      if (wr_en && hit(i_paddr, `PDRC_OFS_OE)) begin
        oe_q <= i_pwdata[7:0];
      end
      if (wr_en && hit(i_paddr, `PDRC_OFS_UID)) begin
        uid_q <= i_pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 32'h00000000;
    err_d = !mapped(i_paddr);
    // Narrow registers read zero above their width
    case (i_paddr)
      `PDRC_OFS_CTRL: begin
        rdata_d[1:0] = ctrl_q;
      end
      `PDRC_OFS_RPWR: begin
        rdata_d[7:0] = rpwr_q;
      end
      `PDRC_OFS_SLEW: begin
        rdata_d[7:0] = slew_q;
      end
      `PDRC_OFS_POL: begin
        rdata_d[7:0] = pol_q;
      end
      `PDRC_OFS_OE: begin
        rdata_d[7:0] = oe_q;
      end
      `PDRC_OFS_STATUS: begin
        rdata_d[`PDRC_ST_ASLEEP] = asleep_q;
        rdata_d[`PDRC_ST_SETTLING] = settling_q;
        rdata_d[`PDRC_ST_FUSE] = fuse;
      end
      `PDRC_OFS_UID: begin
        rdata_d[15:0] = uid_q;
      end
      `PDRC_OFS_PAT: begin
        if (fuse && !i_pwrite) begin
          err_d = 1'b1;
        end else begin
          rdata_d = pat_q;
        end
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else if (setup) begin
      // Answer registered, stands one cycle
      o_pready <= 1'b1;
      o_pslverr <= err_d;
      o_prdata <= i_pwrite ? 32'h00000000 : rdata_d;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> test/pdrc_props.sv
// Purpose: Port-level checks of power-down and reset control
// Assumes: Bound to pdrc_top; one clock domain
// Notes:   Sees only top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "pdrc_consts.vh"
module pdrc_props (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_sleep_request_a,
  input wire logic i_sleep_request_b,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe_n,
  input wire logic [7:0] o_fast_slew,
  input wire logic o_asleep
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_sleep_entry: assert property (
    $rose(o_asleep) |-> $past(i_sleep_request_a | i_sleep_request_b))
    else $error("asleep without request");
  a_sleep_exit: assert property (
    o_asleep && !i_sleep_request_a && !i_sleep_request_b |=> !o_asleep)
    else $error("asleep held after release");
  a_outs_frozen: assert property (
    o_asleep ##1 o_asleep |-> $stable(o_pin_out) && $stable(o_pin_oe_n)
    && $stable(o_fast_slew)) else $error("outputs moved while asleep");
  a_resume_held: assert property (
    $fell(o_asleep) |-> $stable(o_pin_out)) else $error("outputs lost on exit");
  a_reset_vals: assert property (
    $rose(i_nrst) |-> o_pin_oe_n == 8'hff && o_fast_slew == 8'h00
    && o_pin_out == 8'h00) else $error("bad output state after reset");
  a_sleep_pins: assert property (
    o_asleep |-> &o_pin_oe_n[1:0]) else $error("sleep pin driven");
  a_err_data: assert property (
    o_pslverr |-> o_prdata == 32'h0) else $error("data on refused read");
  a_uid_open: assert property (
    o_pready && i_psel && i_paddr == `PDRC_OFS_UID |-> !o_pslverr)
    else $error("user id refused");
  c_enter: cover property ($rose(o_asleep));
  c_leave: cover property ($fell(o_asleep));
  c_refuse: cover property (o_pslverr);
endmodule
bind pdrc_top pdrc_props u_props (.*);
`default_nettype wire

// >>> test/pdrc_sys.sv
// Purpose: External system driving sleep pins, pins and config port
// Assumes: Tasks called right after a core clock edge
// Notes:   Config clock stands low outside loads; idle lines high
`timescale 1ns/1ps
`default_nettype none
module pdrc_sys (
  input wire logic i_core_clk,
  input wire logic i_tdo,
  output logic o_sleep_request_a = 1'b0,
  output logic o_sleep_request_b = 1'b0,
  output logic [7:0] o_pin_in = 8'h00,
  output logic o_tck = 1'b0,
  output logic o_tms = 1'b1,
  output logic o_tdi = 1'b1
);
  task drive_sleep(input logic a, input logic b);
    @(posedge i_core_clk);
    o_sleep_request_a <= a;
    o_sleep_request_b <= b;
  endtask
  task drive_pins(input logic [7:0] v);
    @(posedge i_core_clk);
    o_pin_in <= v;
  endtask
  task load(input logic [31:0] w, output logic [31:0] r);
    r = 32'h00000000;
    for (int i = 0; i < 33; i++) begin
      @(posedge i_core_clk);
      o_tms <= (i == 32);
      o_tdi <= (i < 32) ? w[i[4:0]] : 1'b1;
      repeat (2) @(posedge i_core_clk);
      o_tck <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      o_tck <= 1'b0;
      // Serial output of the previous capture
      if (i < 32) r[i[4:0]] = i_tdo;
    end
  endtask
endmodule
`default_nettype wire

// >>> test/power_down_and_reset_control_tb_top.sv
// Purpose: Self-checking bench of power-down and reset control
// Assumes: 125 MHz clock; APB master in this module
// Notes:   Partner model drives sleep, pin and config lines
`timescale 1ns/1ps
`default_nettype none
`include "pdrc_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module power_down_and_reset_control_tb_top;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, sa, sb, tck, tms, tdi, tdo, asleep;
  wire [7:0] pin_in, pin_out, oe_n, fast;
  int n_fail = 0, checked = 0, cyc = 0;
  always #4 clk = ~clk;
  pdrc_top u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sleep_request_a(sa), .i_sleep_request_b(sb), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe_n(oe_n), .o_fast_slew(fast),
    .o_asleep(asleep), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo));
  pdrc_sys u_sys (.i_core_clk(clk), .i_tdo(tdo), .o_sleep_request_a(sa),
    .o_sleep_request_b(sb), .o_pin_in(pin_in), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi));
  task results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, ed,
    input logic ee);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) `CHK(prdata, ed)
    `CHK(pslverr, ee)
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(oe_n, 8'hff)
    `CHK(fast, 8'h00)
    for (int i = 0; i < 9; i++) apb(0, 8'(i * 4), 0, 0, i == 8);
    $display("test reset done");
    apb(1, `PDRC_OFS_POL, 32'h0f, 0, 0);
    apb(1, `PDRC_OFS_OE, 32'hff, 0, 0);
    apb(1, `PDRC_OFS_SLEW, 32'h81, 0, 0);
    u_sys.drive_pins(8'hf0);
    repeat (4) @(posedge clk);
    `CHK(pin_out, 8'hff)
    `CHK(oe_n, 8'h00)
    `CHK(fast, 8'h81)
    u_sys.drive_sleep(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    `CHK(asleep, 1'b0)
    `CHK(pin_out, 8'hfe)
    u_sys.drive_sleep(1'b0, 1'b0);
    apb(1, `PDRC_OFS_CTRL, 32'h1, 0, 0);
    repeat (4) @(posedge clk);
    `CHK(oe_n, 8'h03)
    `CHK(pin_out, 8'hff)
    $display("test option done");
    u_sys.drive_sleep(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    `CHK(asleep, 1'b1)
    apb(0, `PDRC_OFS_STATUS, 0, 32'h1, 0);
    u_sys.drive_pins(8'h00);
    repeat (4) @(posedge clk);
    `CHK(pin_out, 8'hff)
    u_sys.drive_sleep(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    `CHK(asleep, 1'b0)
    `CHK(pin_out, 8'h0f)
    apb(0, `PDRC_OFS_POL, 0, 32'h0f, 0);
    $display("test sleep done");
    apb(1, `PDRC_OFS_RPWR, 32'h80, 0, 0);
    u_sys.drive_pins(8'hc0);
    repeat (3) @(posedge clk);
    `CHK(pin_out, 8'h4f)
    @(posedge clk);
    `CHK(pin_out, 8'hcf)
    $display("test reduced power done");
    apb(1, `PDRC_OFS_PAT, 32'ha5a50000, 0, 0);
    u_sys.load(32'h12340000, rd);
    `CHK(rd, 32'h00000000)
    repeat (2) @(posedge clk);
    apb(0, `PDRC_OFS_PAT, 0, 32'h12340000, 0);
    u_sys.load(32'h12340000, rd);
    `CHK(rd, 32'ha5a50000)
    apb(1, `PDRC_OFS_UID, 32'hbeef, 0, 0);
    apb(1, `PDRC_OFS_CTRL, 32'h3, 0, 0);
    u_sys.load(32'h12340000, rd);
    `CHK(rd, 32'h00000000)
    apb(0, `PDRC_OFS_PAT, 0, 0, 1);
    apb(0, `PDRC_OFS_UID, 0, 32'hbeef, 0);
    apb(1, `PDRC_OFS_CTRL, 32'h1, 0, 0);
    apb(0, `PDRC_OFS_CTRL, 0, 32'h3, 0);
    $display("test fuse done");
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(oe_n, 8'hff)
    `CHK(pin_out, 8'h00)
    nrst <= 1'b1;
    apb(0, `PDRC_OFS_STATUS, 0, 32'h2, 0);
    apb(0, `PDRC_OFS_CTRL, 0, 0, 0);
    $display("test reset again done");
    results();
  end
endmodule
`default_nettype wire
